// >>> inc/apd_pkg.sv
`default_nettype none
package apd_pkg;
  // Widths of the datapath.
  localparam int SAMPLE_W = 24;
  localparam int PROD_W = 48;
  localparam int ACC_W = 64;
  // Decimation: CIC of order 3, ratio 64 (gain 2^18, growth 18 bits).
  localparam int DEC_RATIO = 64;
  localparam int DEC_CNT_W = 6;
  localparam int CIC_W = 21;
  localparam int CIC_SHIFT = 0;
  // High-pass and low-pass filter shifts (single pole).
  localparam int HPF_SHIFT = 10;
  localparam int LPF_SHIFT = 8;
  // Clock rate.
  localparam int CLK_KHZ = 450;
  // Pulse thresholds for the slow outputs, picked by rate select.
  localparam logic [63:0] SLOW_THR0 = 64'h0000_1000_0000_0000;
  localparam logic [63:0] SLOW_THR1 = 64'h0000_0800_0000_0000;
  localparam logic [63:0] SLOW_THR2 = 64'h0000_0400_0000_0000;
  localparam logic [63:0] SLOW_THR3 = 64'h0000_0200_0000_0000;
  // Calibration output thresholds: the slow one divided by 2048 or 1024.
  localparam int CAL_DIV_SHIFT_HI = 11;
  localparam int CAL_DIV_SHIFT_LO = 10;
  // Length of an output pulse in clocks.
  localparam logic [7:0] PULSE_LEN = 8'h10;
  localparam logic [7:0] CAL_PULSE_LEN = 8'h01;
  localparam int FIFO_DEPTH = 8;

  // One decimated sample pair.
  typedef struct packed {
    logic [SAMPLE_W-1:0] cur;
    logic [SAMPLE_W-1:0] volt;
  } apd_pair_t;

  typedef enum logic [1:0] {
    APD_RUN_IDLE = 2'b01,
    APD_RUN_BUSY = 2'b10
  } apd_run_t;
endpackage
`default_nettype wire

// >>> design/apd_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Small synchronous FIFO.
// ----------------------------------------
module apd_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  // Storage array.
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ff];

  // Write side stores a word when there is room.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // apd_fifo
`default_nettype wire

// >>> design/apd_datapath.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - One modulator bit per channel each clock.
// - Decimate bitstreams to signed 24-bit samples.
// - Exactly one current input feeds power.
// - High-pass removes dc from current only.
// - Multiply filtered current by voltage sample.
// - Low-pass product gives active power.
// - Slow pulses accumulate power over long interval.
// - Calibration pulse uses much shorter interval.
// - All pulse timing from master clock only.
// - Filters keep 40 Hz to 1 kHz content.
// - Two selects choose four slow rates.
module apd_datapath (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic current_input_a,
  input wire logic current_input_b,
  input wire logic voltage_input_pos,
  input wire logic use_input_b,
  input wire logic rate_select_hi,
  input wire logic rate_select_lo,
  input wire logic calib_rate_select,
  output logic slow_pulse_out_a,
  output logic slow_pulse_out_b,
  output logic calibration_pulse_out,
  output logic [23:0] active_power
);
  // ----------------------------------------
  // Reset synchroniser.
  // ----------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------
  // Decimation filters.
  // ----------------------------------------
  // Maps a modulator bit to +1 or -1.
  function automatic logic [apd_pkg::CIC_W-1:0] bit_val(input logic b);
    bit_val = b ? apd_pkg::CIC_W'(1) : {apd_pkg::CIC_W{1'b1}};
  endfunction

  logic sel_bit;
  assign sel_bit = use_input_b ? current_input_b : current_input_a;
  // Integrators, two channels by three stages.
  logic [apd_pkg::CIC_W-1:0] int_ff [2][3];
  logic [apd_pkg::CIC_W-1:0] comb_ff [2][3];
  logic [apd_pkg::CIC_W-1:0] c1 [2];
  logic [apd_pkg::CIC_W-1:0] c2 [2];
  logic [apd_pkg::CIC_W-1:0] c3 [2];
  logic [apd_pkg::DEC_CNT_W-1:0] dec_cnt_ff;
  logic dec_tick;
  logic [1:0] mod_bits;
  assign mod_bits = {voltage_input_pos, sel_bit};
  assign dec_tick = (dec_cnt_ff == apd_pkg::DEC_CNT_W'(apd_pkg::DEC_RATIO - 1));

  // Every clock takes a bit per channel into the integrators.
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      for (int c = 0; c < 2; c++) begin
        for (int s = 0; s < 3; s++) begin
          int_ff[c][s] <= '0;
        end
      end
      dec_cnt_ff <= '0;
    end else begin
      dec_cnt_ff <= dec_cnt_ff + 1'b1;
      for (int c = 0; c < 2; c++) begin
        int_ff[c][0] <= int_ff[c][0] + bit_val(mod_bits[c]);
        int_ff[c][1] <= int_ff[c][1] + int_ff[c][0];
        int_ff[c][2] <= int_ff[c][2] + int_ff[c][1];
      end
    end
  end

  // Comb section differentiates at the output rate.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      c1[c] = int_ff[c][2] - comb_ff[c][0];
      c2[c] = c1[c] - comb_ff[c][1];
      c3[c] = c2[c] - comb_ff[c][2];
    end
  end

  logic [1:0][apd_pkg::SAMPLE_W-1:0] dec_ff;
  logic dec_valid_ff;
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      for (int c = 0; c < 2; c++) begin
        for (int s = 0; s < 3; s++) begin
          comb_ff[c][s] <= '0;
        end
        dec_ff[c] <= '0;
      end
      dec_valid_ff <= 1'b0;
    end else begin
      dec_valid_ff <= dec_tick;
      if (dec_tick) begin
        for (int c = 0; c < 2; c++) begin
          comb_ff[c][0] <= int_ff[c][2];
          comb_ff[c][1] <= c1[c];
          comb_ff[c][2] <= c2[c];
          // Sign extend the 21-bit result to 24 bits.
          dec_ff[c] <= {{3{c3[c][apd_pkg::CIC_W-1]}}, c3[c]};
        end
      end
    end
  end

  // ----------------------------------------
  // Sample FIFO.
  // ----------------------------------------
  apd_pkg::apd_pair_t fifo_in;
  apd_pkg::apd_pair_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic proc_ready;
  assign fifo_in.cur = dec_ff[0];
  assign fifo_in.volt = dec_ff[1];

  apd_fifo #(
    .WIDTH(2 * apd_pkg::SAMPLE_W),
    .DEPTH(apd_pkg::FIFO_DEPTH)
  ) u_apd_fifo (
    .clk(clk),
    .rst_n(rst_n_ff),
    .in_data(fifo_in),
    .in_valid(dec_valid_ff),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(proc_ready)
  );

  // ----------------------------------------
  // Power stage: high-pass, multiply, low-pass, two cycles per sample.
  // ----------------------------------------
  apd_pkg::apd_run_t run_ff;
  assign proc_ready = (run_ff == apd_pkg::APD_RUN_IDLE);
  logic signed [apd_pkg::ACC_W-1:0] hpf_ff;
  logic signed [apd_pkg::SAMPLE_W-1:0] cur_hp_ff;
  logic signed [apd_pkg::SAMPLE_W-1:0] volt_ff;
  logic signed [apd_pkg::ACC_W-1:0] lpf_ff;
  logic signed [apd_pkg::ACC_W-1:0] cur_ext;
  logic signed [apd_pkg::PROD_W-1:0] prod;
  logic pwr_valid_ff;
  assign cur_ext = {{(apd_pkg::ACC_W-apd_pkg::SAMPLE_W){fifo_out.cur[23]}}, fifo_out.cur};
  assign prod = cur_hp_ff * volt_ff;

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      run_ff <= apd_pkg::APD_RUN_IDLE;
      hpf_ff <= '0;
      cur_hp_ff <= '0;
      volt_ff <= '0;
      lpf_ff <= '0;
      pwr_valid_ff <= 1'b0;
    end else begin
      pwr_valid_ff <= 1'b0;
      case (run_ff)
        apd_pkg::APD_RUN_IDLE: begin
          if (fifo_out_valid) begin
            // Track the dc level and subtract it from the current.
            hpf_ff <= hpf_ff + ((cur_ext - hpf_ff) >>> apd_pkg::HPF_SHIFT);
            cur_hp_ff <= apd_pkg::SAMPLE_W'(cur_ext - hpf_ff);
            volt_ff <= fifo_out.volt;
            run_ff <= apd_pkg::APD_RUN_BUSY;
          end
        end
        apd_pkg::APD_RUN_BUSY: begin
          lpf_ff <= lpf_ff + ((apd_pkg::ACC_W'(prod) - lpf_ff) >>> apd_pkg::LPF_SHIFT);
          pwr_valid_ff <= 1'b1;
          run_ff <= apd_pkg::APD_RUN_IDLE;
        end
        default: begin
          run_ff <= apd_pkg::APD_RUN_IDLE;
        end
      endcase
    end
  end

  logic [apd_pkg::SAMPLE_W-1:0] pwr_ff;
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pwr_ff <= '0;
    end else if (pwr_valid_ff) begin
      pwr_ff <= lpf_ff[47:24];
    end
  end
  assign active_power = pwr_ff;

  // ----------------------------------------
  // Digital-to-frequency conversion.
  // ----------------------------------------
  logic [apd_pkg::ACC_W-1:0] slow_thr;
  logic [apd_pkg::ACC_W-1:0] cal_thr;
  always_comb begin
    case ({rate_select_hi, rate_select_lo})
      2'b00: slow_thr = apd_pkg::SLOW_THR0;
      2'b01: slow_thr = apd_pkg::SLOW_THR1;
      2'b10: slow_thr = apd_pkg::SLOW_THR2;
      default: slow_thr = apd_pkg::SLOW_THR3;
    endcase
    cal_thr = calib_rate_select ? (slow_thr >> apd_pkg::CAL_DIV_SHIFT_HI)
                                : (slow_thr >> apd_pkg::CAL_DIV_SHIFT_LO);
  end

  logic signed [apd_pkg::ACC_W-1:0] slow_acc_ff;
  logic signed [apd_pkg::ACC_W-1:0] cal_acc_ff;
  logic signed [apd_pkg::ACC_W-1:0] pwr_ext;
  logic [7:0] slow_len_ff;
  logic [7:0] cal_len_ff;
  logic slow_phase_ff;
  assign pwr_ext = lpf_ff;

  // Accumulators add power each sample and fire at threshold.
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      slow_acc_ff <= '0;
      cal_acc_ff <= '0;
      slow_len_ff <= '0;
      cal_len_ff <= '0;
      slow_phase_ff <= 1'b0;
    end else begin
      if (slow_len_ff != 8'h00) begin
        slow_len_ff <= slow_len_ff - 1'b1;
      end
      if (cal_len_ff != 8'h00) begin
        cal_len_ff <= cal_len_ff - 1'b1;
      end
      if (pwr_valid_ff) begin
        if (slow_acc_ff + pwr_ext >= $signed(slow_thr)) begin
          slow_acc_ff <= slow_acc_ff + pwr_ext - $signed(slow_thr);
          slow_len_ff <= apd_pkg::PULSE_LEN;
          slow_phase_ff <= ~slow_phase_ff;
        end else begin
          slow_acc_ff <= slow_acc_ff + pwr_ext;
        end
        if (cal_acc_ff + pwr_ext >= $signed(cal_thr)) begin
          cal_acc_ff <= cal_acc_ff + pwr_ext - $signed(cal_thr);
          cal_len_ff <= apd_pkg::CAL_PULSE_LEN;
        end else begin
          cal_acc_ff <= cal_acc_ff + pwr_ext;
        end
      end
    end
  end

  // Output pulses, registered; the slow pulses alternate between a and b.
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      slow_pulse_out_a <= 1'b0;
      slow_pulse_out_b <= 1'b0;
      calibration_pulse_out <= 1'b0;
    end else begin
      slow_pulse_out_a <= (slow_len_ff != 8'h00) && slow_phase_ff;
      slow_pulse_out_b <= (slow_len_ff != 8'h00) && !slow_phase_ff;
      calibration_pulse_out <= (cal_len_ff != 8'h00);
    end
  end

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  a_dec_rate: assert property (@(posedge clk) disable iff (!rst_n_ff)
    dec_tick |=> !dec_tick [*8]) else $error("decimation tick too frequent");
  a_fifo_flow: assert property (@(posedge clk) disable iff (!rst_n_ff)
    dec_valid_ff |-> fifo_in_ready) else $error("sample lost at fifo");
  a_one_input: assert property (@(posedge clk) disable iff (!rst_n_ff)
    mod_bits[0] == (use_input_b ? current_input_b : current_input_a))
    else $error("bad input select");
  a_mult_step: assert property (@(posedge clk) disable iff (!rst_n_ff)
    (run_ff == apd_pkg::APD_RUN_BUSY) |=> pwr_valid_ff) else $error("product not filtered");
  a_run_alt: assert property (@(posedge clk) disable iff (!rst_n_ff)
    pwr_valid_ff |-> $past(run_ff == apd_pkg::APD_RUN_BUSY)) else $error("power without sample");
  a_cal_short: assert property (@(posedge clk) disable iff (!rst_n_ff)
    cal_thr < slow_thr) else $error("calibration threshold not shorter");
  a_slow_len: assert property (@(posedge clk) disable iff (!rst_n_ff)
    $rose(slow_len_ff != 8'h00) |=> (slow_pulse_out_a || slow_pulse_out_b)) else $error("no slow pulse");
  a_acc_below: assert property (@(posedge clk) disable iff (!rst_n_ff)
    $past(pwr_valid_ff) |-> (slow_acc_ff < $signed(slow_thr))) else $error("accumulator left at threshold");
endmodule // apd_datapath
`default_nettype wire

// >>> bench/apd_modulator.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Modulator model: one first-order loop per channel.
// ----------------------------------------
module apd_modulator #(
  parameter int HALF_PERIOD = 2048
) (
  input wire logic clk,
  input wire logic signed [15:0] amp_cur_a,
  input wire logic signed [15:0] amp_cur_b,
  input wire logic signed [15:0] amp_volt,
  output logic current_input_a,
  output logic current_input_b,
  output logic voltage_input_pos
);
  localparam int FULL_SCALE = 32768; // Feedback level of the one-bit converter.
  int integ_ff[3] = '{0, 0, 0}; // Loop integrators.
  logic [2:0] bit_ff = 3'h0; // Present output bits.
  logic sq_ff = 1'b0; // Square-wave phase shared by all channels.
  int phase_ff = 0; // Clocks spent in the present half period.
  int amp_i[3]; // Working copies of the levels.
  int nxt_integ; // Next integrator value.
  // The bits change at the falling edge so the device samples settled lines.
  always @(negedge clk) begin
    amp_i[0] = amp_cur_a;
    amp_i[1] = amp_cur_b;
    amp_i[2] = amp_volt;
    if (phase_ff == HALF_PERIOD - 1) begin
      phase_ff <= 0;
      sq_ff <= ~sq_ff;
    end else begin
      phase_ff <= phase_ff + 1;
    end
    for (int i = 0; i < 3; i++) begin
      nxt_integ = integ_ff[i] + (sq_ff ? amp_i[i] : -amp_i[i]);
      nxt_integ = nxt_integ - (bit_ff[i] ? FULL_SCALE : -FULL_SCALE);
      integ_ff[i] <= nxt_integ;
      bit_ff[i] <= (nxt_integ >= 0);
    end
  end
  assign current_input_a = bit_ff[0];
  assign current_input_b = bit_ff[1];
  assign voltage_input_pos = bit_ff[2];
endmodule // apd_modulator
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int CASE_LEN = 15000; // Clocks observed per case.
  // Square-wave level near full scale, so the slow pulse fires inside one case.
  localparam logic signed [15:0] AMP = 16'sh7530;
  logic clk = 1'b0; // Clock.
  logic arst_n = 1'b0; // Reset, active low.
  logic use_input_b = 1'b0; // Current input choice.
  logic rate_select_hi = 1'b0; // Slow rate choice, high bit.
  logic rate_select_lo = 1'b0; // Slow rate choice, low bit.
  logic calib_rate_select = 1'b0; // Calibration rate choice.
  logic signed [15:0] amp_a = 16'sh0; // Level on current input a.
  logic signed [15:0] amp_b = 16'sh0; // Level on current input b.
  logic signed [15:0] amp_v = 16'sh0; // Level on the voltage input.
  wire cur_a_bit, cur_b_bit, volt_bit; // Modulator streams.
  wire slow_a, slow_b, cal_out; // Pulse outputs.
  wire [23:0] active_power; // Filtered power.
  logic signed [23:0] ap_ref; // Power seen in the reference case.
  logic counting = 1'b0; // Pulse monitor enable.
  int fails = 0;
  int num_checks = 0;
  int n_a, n_b, n_cal, len_a, len_b, len_c, last, alt_err, width_err, slow_ref, cal_ref;
  // ----------------------------------------
  // Clock and instances
  // ----------------------------------------
  always #2.5 clk = ~clk;
  apd_modulator u_apd_modulator (.clk(clk), .amp_cur_a(amp_a), .amp_cur_b(amp_b),
    .amp_volt(amp_v), .current_input_a(cur_a_bit), .current_input_b(cur_b_bit),
    .voltage_input_pos(volt_bit));
  apd_datapath u_apd_datapath (.clk(clk), .arst_n(arst_n), .current_input_a(cur_a_bit),
    .current_input_b(cur_b_bit), .voltage_input_pos(volt_bit), .use_input_b(use_input_b),
    .rate_select_hi(rate_select_hi), .rate_select_lo(rate_select_lo),
    .calib_rate_select(calib_rate_select), .slow_pulse_out_a(slow_a),
    .slow_pulse_out_b(slow_b), .calibration_pulse_out(cal_out),
    .active_power(active_power));
  // ----------------------------------------
  // Pulse monitor
  // ----------------------------------------
  // Counts pulses and flags any pulse whose length is wrong.
  task automatic watch(input logic lvl, inout int len, inout int n, input int want);
    if (lvl === 1'b1) begin
      n = (len == 0) ? n + 1 : n;
      len++;
    end else begin
      if (len != 0 && len != want) width_err++;
      len = 0;
    end
  endtask
  // The slow outputs must take turns, so a repeat on one side is an error.
  // Outputs are read at the falling edge, half a period after they settle.
  always @(negedge clk) begin
    if (counting) begin
      watch(slow_a, len_a, n_a, 16);
      watch(slow_b, len_b, n_b, 16);
      watch(cal_out, len_c, n_cal, 1);
      if (len_a == 1) begin
        alt_err += (last == 1);
        last = 1;
      end
      if (len_b == 1) begin
        alt_err += (last == 2);
        last = 2;
      end
    end
  end
  // ----------------------------------------
  // Compare tasks
  // ----------------------------------------
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic chk_int(input string nm, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      fails++;
      $display("ERROR %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic chk_more(input string nm, input int lo, input int got);
    num_checks++;
    if (got <= lo) begin
      fails++;
      $display("ERROR %s expected above %0d seen %0d", nm, lo, got);
    end
  endtask
  // ----------------------------------------
  // Shared case runner: reset, set levels, observe.
  // ----------------------------------------
  task automatic run_case(input logic signed [15:0] a, b, v, input logic sb, hi, lo, cs);
    @(negedge clk);
    arst_n = 1'b0;
    counting = 1'b0;
    {amp_a, amp_b, amp_v} = {a, b, v};
    {use_input_b, rate_select_hi, rate_select_lo, calib_rate_select} = {sb, hi, lo, cs};
    repeat (2) @(negedge clk);
    {n_a, n_b, n_cal, len_a, len_b, len_c, last, alt_err, width_err} = '0;
    arst_n = 1'b1;
    counting = 1'b1;
    repeat (CASE_LEN) @(negedge clk);
    counting = 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // In-phase signals on input a at the fastest slow rate.
  task automatic case_in_phase();
    run_case(AMP, 0, AMP, 1'b0, 1'b1, 1'b1, 1'b0);
    ap_ref = active_power;
    slow_ref = n_a + n_b;
    cal_ref = n_cal;
    chk_bit("power sign", 1'b0, active_power[23]);
    chk_more("power size", 0, int'(ap_ref));
    chk_more("slow pulses", 0, slow_ref);
    chk_more("cal above slow", slow_ref, cal_ref);
    chk_int("slow order", 0, alt_err);
    chk_int("pulse width", 0, width_err);
  endtask
  // Slowest rate with the finer calibration divider.
  // The calibration threshold here is four times the one of the first case,
  // so fewer calibration pulses must come, yet still more than slow ones.
  task automatic case_rates();
    run_case(AMP, 0, AMP, 1'b0, 1'b0, 1'b0, 1'b1);
    chk_more("slow rate order", n_a + n_b, slow_ref);
    chk_more("cal divider", n_cal, cal_ref);
    chk_more("cal above slow rate 0", n_a + n_b, n_cal);
    chk_int("pulse width", 0, width_err);
  endtask
  // Only the selected current input may feed the product.
  task automatic case_input_sel();
    run_case(AMP, 0, AMP, 1'b1, 1'b0, 1'b1, 1'b0);
    chk_bit("unused input", 1'b1, ($signed(active_power) < (ap_ref >>> 4)) &&
      ($signed(active_power) > -(ap_ref >>> 4)));
    chk_int("unused input pulses", 0, n_a + n_b);
    run_case(0, AMP, AMP, 1'b1, 1'b1, 1'b1, 1'b0);
    chk_bit("input b sign", 1'b0, active_power[23]);
    chk_more("input b pulses", 0, n_a + n_b);
  endtask
  // Current opposite to voltage gives negative power and no pulses.
  task automatic case_reverse();
    run_case(AMP, 0, -AMP, 1'b0, 1'b1, 1'b0, 1'b0);
    chk_bit("reverse sign", 1'b1, active_power[23]);
    chk_int("reverse pulses", 0, n_a + n_b + n_cal);
  endtask
  // ----------------------------------------
  // Verdict and main sequence
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    case_in_phase();
    case_rates();
    case_input_sel();
    case_reverse();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
